// ### rtl/slpclk_pkg.sv
package slpclk_pkg;
    // register byte addresses on the apb bus
    localparam logic [7:0] SLPCLK_TRIM_A_ADDR = 8'h10;
    localparam logic [7:0] SLPCLK_TRIM_B_ADDR = 8'h14;
    localparam logic [7:0] SLPCLK_LPOSC_ADDR = 8'h18;
    localparam logic [7:0] SLPCLK_XOSC_ADDR = 8'h1C;
    localparam logic [7:0] SLPCLK_SLEEP_ADDR = 8'h20;
    localparam logic [7:0] SLPCLK_STATUS_ADDR = 8'h24;
    localparam logic [7:0] SLPCLK_PROTECT_ADDR = 8'h28;
    // protected-write unlock key and window
    localparam logic [7:0] SLPCLK_UNLOCK_KEY = 8'hD8;
    localparam logic [3:0] SLPCLK_UNLOCK_CYCLES = 4'h4;
    // field positions
    localparam int SLPCLK_XEN_BIT = 0;
    localparam int SLPCLK_XRSB_BIT = 1;
    localparam int SLPCLK_XSEL_BIT = 2;
    localparam int SLPCLK_CRYSTAL_STARTUP_COUNT_LSB = 4;
    localparam int SLPCLK_LPRSB_BIT = 1;
    localparam int SLPCLK_LOCK_BIT = 7;
    // reset values
    localparam logic [7:0] SLPCLK_CTRL_RESET = 8'h00;
    // crystal start-up counts in crystal cycles
    localparam logic [16:0] SLPCLK_SU_1K = 17'h00400;
    localparam logic [16:0] SLPCLK_SU_16K = 17'h04000;
    localparam logic [16:0] SLPCLK_SU_32K = 17'h08000;
    localparam logic [16:0] SLPCLK_SU_64K = 17'h10000;
    // gate delays in oscillator cycles
    localparam logic [2:0] SLPCLK_LP_GATE = 3'h4;
    localparam logic [2:0] SLPCLK_X_GATE = 3'h2;
    // wake-up delay in peripheral clock cycles
    localparam logic [2:0] SLPCLK_WAKE_CYC = 3'h6;
    // sleep mode encodings and the brown-out wait fuse code
    localparam logic [1:0] SLPCLK_SM_IDLE = 2'h0;
    localparam logic [1:0] SLPCLK_SM_STBY = 2'h1;
    localparam logic [1:0] SLPCLK_SM_POWER_DOWN_MODE = 2'h2;
    localparam logic [1:0] SLPCLK_BOD_WAIT = 2'h3;
    typedef enum logic [4:0] {
        SLPCLK_ACTIVE = 5'h01,
        SLPCLK_IDLE = 5'h02,
        SLPCLK_STBY = 5'h04,
        SLPCLK_POWER_DOWN_MODE = 5'h08,
        SLPCLK_WAKE = 5'h10
    } slpclk_mode_type;
endpackage

// ### rtl/slpclk_ctrl.sv
`timescale 1ns/1ps
module slpclk_ctrl
    import slpclk_pkg::*;
(
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // fuses
    input wire logic trim_lock_fuse_bit,
    input wire logic [1:0] frequency_select_fuse,
    input wire logic [1:0] brownout_config_fuse,
    // cpu and system
    input wire logic sleep_instr,
    input wire logic irq_enabled_any,
    input wire logic wake_irq,
    input wire logic debug_break,
    input wire logic brownout_ready,
    input wire logic main_clock_ready,
    input wire logic [5:0] peripheral_run_in_standby,
    // peripheral clock requests
    input wire logic lp_request,
    input wire logic xosc_request,
    // oscillator ticks from pins (async)
    input wire logic crystal_pin_in,
    input wire logic lp_osc_tick,
    // outputs
    output logic cpu_clock_en,
    output logic cpu_halted,
    output logic [5:0] periph_active,
    output logic main_osc_on,
    output logic lp_osc_on,
    output logic lp_clock_gate,
    output logic xosc_on,
    output logic xosc_clock_gate,
    output logic crystal_pin_override,
    output logic crystal_pin_out_en,
    output logic [5:0] fast_osc_trim_a,
    output logic [3:0] temp_slope_trim
);

    typedef struct packed {
        logic [1:0] xtick_s;
        logic [1:0] ltick_s;
        logic xtick_p;
        logic ltick_p;
        logic [5:0] trim_a;
        logic [3:0] trim_b;
        logic lock;
        logic lp_rsb;
        logic x_en;
        logic x_rsb;
        logic x_sel;
        logic [1:0] crystal_startup_count;
        logic [1:0] sleep_mode_field;
        logic sleep_enable_bit;
        logic [3:0] unlock;
        logic [16:0] su_cnt;
        logic x_started;
        logic [2:0] x_gate_cnt;
        logic [2:0] lp_gate_cnt;
        logic [2:0] wake_cnt;
        logic main_was_off;
        slpclk_mode_type mode;
        logic strap_done;
    } slpclk_state_type;

    slpclk_state_type s_q, s_d;
    logic wr, rd, xtick, ltick, x_stable, x_run, lp_run, in_sleep, wake_req;
    logic [16:0] su_target;

    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign xtick = s_q.xtick_s[1] && !s_q.xtick_p;
    assign ltick = s_q.ltick_s[1] && !s_q.ltick_p;
    assign x_stable = s_q.x_started && xosc_request;
    assign in_sleep = s_q.mode != SLPCLK_ACTIVE && s_q.mode != SLPCLK_WAKE;

    // start-up count per field; external clock needs none
    always_comb begin
        unique case (s_q.crystal_startup_count)
            2'h0: su_target = SLPCLK_SU_1K;
            2'h1: su_target = SLPCLK_SU_16K;
            2'h2: su_target = SLPCLK_SU_32K;
            default: su_target = SLPCLK_SU_64K;
        endcase
    end

    // crystal runs on request, or always outside power-down with run-in-standby
    assign x_run = s_q.x_en && (xosc_request
        || (s_q.x_rsb && s_q.mode != SLPCLK_POWER_DOWN_MODE));
    assign lp_run = lp_request || s_q.lp_rsb;
    // only interrupts permitted by the current mode wake; irqs filtered upstream
    assign wake_req = irq_enabled_any && wake_irq;

    // next-state logic
    always_comb begin
        s_d = s_q;
        // two-flop synchronisers on the free-running oscillator pins;
        // only the second stage feeds the edge detectors, never the first
        s_d.xtick_s = {s_q.xtick_s[0], crystal_pin_in};
        s_d.ltick_s = {s_q.ltick_s[0], lp_osc_tick};
        s_d.xtick_p = s_q.xtick_s[1];
        s_d.ltick_p = s_q.ltick_s[1];
        // fuse-derived values captured once after reset release
        if (!s_q.strap_done) begin
            s_d.strap_done = 1'b1;
            s_d.lock = trim_lock_fuse_bit;
            s_d.trim_b = {2'h2, frequency_select_fuse};
            s_d.trim_a = {4'h8, frequency_select_fuse};
        end
        // unlock window counts down every cycle; a late crystal write cannot change x_en or x_rsb
        if (s_q.unlock != 4'h0)
            s_d.unlock = s_q.unlock - 4'h1;
        if (wr) begin
            unique case (paddr)
                SLPCLK_PROTECT_ADDR:
                    if (pwdata[7:0] == SLPCLK_UNLOCK_KEY)
                        s_d.unlock = SLPCLK_UNLOCK_CYCLES;
                SLPCLK_TRIM_A_ADDR:
                    if (!s_q.lock)
                        s_d.trim_a = pwdata[5:0];
                SLPCLK_TRIM_B_ADDR:
                    if (!s_q.lock)
                        s_d.trim_b = pwdata[3:0];
                SLPCLK_LPOSC_ADDR:
                    s_d.lp_rsb = pwdata[SLPCLK_LPRSB_BIT];
                SLPCLK_XOSC_ADDR: begin
                    // settings frozen while enabled or stable
                    if (!s_q.x_en && !x_stable) begin
                        s_d.x_sel = pwdata[SLPCLK_XSEL_BIT];
                        s_d.crystal_startup_count = pwdata[SLPCLK_CRYSTAL_STARTUP_COUNT_LSB+:2];
                    end
                    if (s_q.unlock != 4'h0) begin
                        s_d.x_en = pwdata[SLPCLK_XEN_BIT];
                        s_d.x_rsb = pwdata[SLPCLK_XRSB_BIT];
                        s_d.unlock = 4'h0;
                    end
                end
                SLPCLK_SLEEP_ADDR: begin
                    s_d.sleep_mode_field = pwdata[2:1];
                    s_d.sleep_enable_bit = pwdata[0];
                end
                default: ;
            endcase
        end
        // crystal start-up, skipped for external clock
        if (!x_run) begin
            s_d.su_cnt = 17'h0;
            s_d.x_gate_cnt = 3'h0;
            if (!s_q.x_en)
                s_d.x_started = 1'b0;
        end else if (!s_q.x_started) begin
            if (s_q.x_sel || s_q.su_cnt >= su_target)
                s_d.x_started = 1'b1;
            else if (xtick)
                s_d.su_cnt = s_q.su_cnt + 17'h1;
        end
        // output gate after start-up: two crystal ticks
        if (!(xosc_request && s_q.x_started))
            s_d.x_gate_cnt = 3'h0;
        else if (xtick && s_q.x_gate_cnt < SLPCLK_X_GATE)
            s_d.x_gate_cnt = s_q.x_gate_cnt + 3'h1;
        // low-power gate opens after four osc ticks
        // limitation: ticks are counted after synchronising, so the gate
        // opens up to three pclk cycles after the fourth oscillator edge
        if (!lp_request)
            s_d.lp_gate_cnt = 3'h0;
        else if (ltick && s_q.lp_gate_cnt < SLPCLK_LP_GATE)
            s_d.lp_gate_cnt = s_q.lp_gate_cnt + 3'h1;
        // sleep state machine
        unique case (s_q.mode)
            SLPCLK_ACTIVE: begin
                s_d.wake_cnt = 3'h0;
                if (sleep_instr && s_q.sleep_enable_bit) begin
                    unique case (s_q.sleep_mode_field)
                        SLPCLK_SM_IDLE: s_d.mode = SLPCLK_IDLE;
                        SLPCLK_SM_STBY: s_d.mode = SLPCLK_STBY;
                        SLPCLK_SM_POWER_DOWN_MODE: s_d.mode = SLPCLK_POWER_DOWN_MODE;
                        default: ; // reserved code, stay active
                    endcase
                    s_d.main_was_off = s_q.sleep_mode_field == SLPCLK_SM_POWER_DOWN_MODE
                        || (s_q.sleep_mode_field == SLPCLK_SM_STBY && !peripheral_run_in_standby[5]);
                end
            end
            SLPCLK_IDLE, SLPCLK_STBY, SLPCLK_POWER_DOWN_MODE:
                if (debug_break || wake_req)
                    s_d.mode = SLPCLK_WAKE;
            SLPCLK_WAKE: begin
                if (s_q.wake_cnt < SLPCLK_WAKE_CYC)
                    s_d.wake_cnt = s_q.wake_cnt + 3'h1;
                // six cycles, main clock start-up, optional brown-out wait
                if (s_q.wake_cnt >= SLPCLK_WAKE_CYC - 3'h1
                    && (!s_q.main_was_off || main_clock_ready)
                    && (brownout_config_fuse != SLPCLK_BOD_WAIT || brownout_ready))
                    s_d.mode = SLPCLK_ACTIVE;
            end
            default: s_d.mode = SLPCLK_ACTIVE;
        endcase
    end

    // state register; retained through sleep, cleared only by reset
    // trade-off: one wide register, so nothing needs a separate retention path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.mode <= SLPCLK_ACTIVE;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs of the sleep modes
    always_comb begin
        cpu_clock_en = s_q.mode == SLPCLK_ACTIVE;
        cpu_halted = in_sleep || s_q.mode == SLPCLK_WAKE;
        unique case (s_q.mode)
            SLPCLK_STBY: periph_active = peripheral_run_in_standby;
            SLPCLK_POWER_DOWN_MODE: periph_active = 6'h00;
            default: periph_active = 6'h3F;
        endcase
        main_osc_on = !(s_q.mode == SLPCLK_POWER_DOWN_MODE
            || (s_q.mode == SLPCLK_STBY && !peripheral_run_in_standby[5]));
    end

    assign lp_osc_on = lp_run;
    assign lp_clock_gate = lp_request && s_q.lp_gate_cnt == SLPCLK_LP_GATE;
    assign xosc_on = x_run;
    assign xosc_clock_gate = s_q.x_gate_cnt == SLPCLK_X_GATE;
    assign crystal_pin_override = s_q.x_en;
    assign crystal_pin_out_en = s_q.x_en && !s_q.x_sel;
    assign fast_osc_trim_a = s_q.trim_a;
    assign temp_slope_trim = s_q.trim_b;
    assign pslverr = 1'b0;

    // read mux; reads have no side effects, so software may poll the
    // crystal stable flag at any unmapped address
    always_comb begin
        prdata = 32'h0;
        if (rd) begin
            unique case (paddr)
                SLPCLK_TRIM_A_ADDR: prdata = {26'h0, s_q.trim_a};
                SLPCLK_TRIM_B_ADDR: prdata = {24'h0, s_q.lock, 3'h0, s_q.trim_b};
                SLPCLK_LPOSC_ADDR: prdata = {30'h0, s_q.lp_rsb, 1'b0};
                SLPCLK_XOSC_ADDR:
                    prdata = {26'h0, s_q.crystal_startup_count, 1'b0, s_q.x_sel, s_q.x_rsb, s_q.x_en};
                SLPCLK_SLEEP_ADDR: prdata = {29'h0, s_q.sleep_mode_field, s_q.sleep_enable_bit};
                SLPCLK_STATUS_ADDR: prdata = {27'h0, s_q.mode};
                default: prdata = {24'h0, 1'b0, x_stable, 6'h0};
            endcase
        end
    end

    // assertions
    // oscillator trim and crystal register protection
    lock_blocks_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.strap_done && s_q.lock |=> $stable(s_q.trim_b))
        else $error("trim changed while locked");
    lock_trim_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.strap_done && s_q.lock |=> $stable(s_q.trim_a))
        else $error("fine trim changed while locked");
    freeze_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.x_en |=> $stable(s_q.x_sel) && $stable(s_q.crystal_startup_count))
        else $error("select changed while enabled");
    protect_en_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.unlock == 4'h0 |=> $stable(s_q.x_en))
        else $error("enable changed without unlock");
    ext_skip_a: assert property (@(posedge pclk) disable iff (!presetn)
        x_run && s_q.x_sel && !s_q.x_started |=> s_q.x_started)
        else $error("external clock waited");
    // clock gates open only on request; the crystal gate closes one cycle after its request drops
    lp_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(lp_clock_gate)
        |-> $past(ltick) && $past(s_q.lp_gate_cnt) == SLPCLK_LP_GATE - 3'h1)
        else $error("low-power gate opened off count");
    xgate_req_a: assert property (@(posedge pclk) disable iff (!presetn)
        !xosc_request |=> !xosc_clock_gate)
        else $error("crystal gate open without request");
    // sleep entry, wake timing and power-down gating
    wake_time_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.mode == SLPCLK_IDLE ##1 s_q.mode == SLPCLK_WAKE
        ##5 (brownout_config_fuse != SLPCLK_BOD_WAIT || brownout_ready)
        |-> !cpu_clock_en ##1 cpu_clock_en)
        else $error("idle wake not six cycles");
    idle_cpu_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.mode == SLPCLK_IDLE |-> !cpu_clock_en && periph_active == 6'h3F && main_osc_on)
        else $error("idle stopped more than cpu");
    no_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
        in_sleep && !irq_enabled_any && !debug_break |=> in_sleep)
        else $error("woke without interrupt");
    sleep_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.mode == SLPCLK_ACTIVE && sleep_instr && s_q.sleep_enable_bit && s_q.sleep_mode_field == SLPCLK_SM_POWER_DOWN_MODE
        |=> s_q.mode == SLPCLK_POWER_DOWN_MODE)
        else $error("power-down not entered");
    reserved_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.mode == SLPCLK_ACTIVE && sleep_instr && s_q.sleep_enable_bit && s_q.sleep_mode_field == 2'h3
        |=> s_q.mode == SLPCLK_ACTIVE)
        else $error("reserved mode entered sleep");
    debug_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
        in_sleep && debug_break |=> s_q.mode == SLPCLK_WAKE)
        else $error("debug break did not wake");
    power_down_mode_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.mode == SLPCLK_POWER_DOWN_MODE |-> !main_osc_on && periph_active == 6'h00)
        else $error("power-down left clocks on");
    // main scenarios for coverage
    cov_idle_c: cover property (@(posedge pclk) s_q.mode == SLPCLK_IDLE ##[1:50] cpu_clock_en);
    cov_stby_c: cover property (@(posedge pclk) s_q.mode == SLPCLK_STBY);
    cov_xstart_c: cover property (@(posedge pclk) $rose(s_q.x_started));
    cov_gate_c: cover property (@(posedge pclk) $rose(lp_clock_gate));
    cov_power_down_mode_c: cover property (@(posedge pclk) s_q.mode == SLPCLK_POWER_DOWN_MODE ##1 s_q.mode == SLPCLK_WAKE);

endmodule // slpclk_ctrl

// ### test/slpclk_xtal_model.sv
`timescale 1ns/1ps
// external 32 kHz source, sped up so start-up counts fit a short run
module slpclk_xtal_model #(
    parameter int HALF_NS = 31
) (
    // control from the block
    input wire logic run,
    // crystal input pin
    output logic osc_pin
);
    // stands still while the block does not run the oscillator
    initial osc_pin = 1'b0;
    always begin
        #(HALF_NS);
        if (run) begin
            osc_pin = ~osc_pin;
        end
    end
endmodule // slpclk_xtal_model

// ### test/sleep_and_low_power_clock_control_tb.sv
`timescale 1ns/1ps
module sleep_and_low_power_clock_control_tb
    import slpclk_pkg::*;
;
    localparam logic [7:0] AX = SLPCLK_XOSC_ADDR;
    localparam logic [7:0] AS = SLPCLK_SLEEP_ADDR;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic lock_f, sleep_instr, irq_en, wake_irq, dbg, bod_rdy, mclk_rdy;
    logic [1:0] fsel, bod_f;
    logic [5:0] prsb, pact, trim_a, v6;
    logic lp_req, x_req, xpin, lp_tick, cpu_en, halted, mosc, lp_on, lp_gate;
    logic x_on, x_gate, x_ovr, x_oe;
    logic [3:0] temp, v4;
    int fails, check_count, cyc, n;

    slpclk_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trim_lock_fuse_bit(lock_f), .frequency_select_fuse(fsel),
        .brownout_config_fuse(bod_f), .sleep_instr(sleep_instr), .irq_enabled_any(irq_en),
        .wake_irq(wake_irq), .debug_break(dbg), .brownout_ready(bod_rdy),
        .main_clock_ready(mclk_rdy), .peripheral_run_in_standby(prsb), .lp_request(lp_req),
        .xosc_request(x_req), .crystal_pin_in(xpin), .lp_osc_tick(lp_tick),
        .cpu_clock_en(cpu_en), .cpu_halted(halted), .periph_active(pact), .main_osc_on(mosc),
        .lp_osc_on(lp_on), .lp_clock_gate(lp_gate), .xosc_on(x_on), .xosc_clock_gate(x_gate),
        .crystal_pin_override(x_ovr), .crystal_pin_out_en(x_oe), .fast_osc_trim_a(trim_a),
        .temp_slope_trim(temp));

    slpclk_xtal_model i_xtal (.run(x_on), .osc_pin(xpin));

    // clocks: low-power ticks unrelated in phase to pclk
    always #10 pclk = ~pclk;
    always #53 lp_tick = ~lp_tick;

    // hang guard, well above the crystal start-up wait
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            results();
        end
    end

    task results;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one apb transfer; keep holds psel so a second setup follows at once
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic keep);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no cap here: only the bench timeout ends a stalled wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        chk("pslverr", 1'b0, pslverr);
        penable <= 1'b0;
        if (!keep) begin
            psel <= 1'b0;
            @(posedge pclk);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 1'b0);
    endtask

    task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, 1'b0);
        chk(nm, e, rd);
    endtask

    // key and crystal write back to back, inside the unlock window
    task unlock(input logic [31:0] d);
        apb(1'b1, SLPCLK_PROTECT_ADDR, {24'h0, SLPCLK_UNLOCK_KEY}, 1'b1);
        apb(1'b1, AX, d, 1'b0);
    endtask

    function logic sig(input int w);
        case (w)
            0: return lp_gate;
            1: return x_gate;
            default: return cpu_en;
        endcase
    endfunction

    task waitfor(input int w, input int lim);
        n = 0;
        while (sig(w) !== 1'b1 && n < lim) begin
            @(posedge pclk);
            n++;
        end
    endtask

    task do_reset(input logic l, input logic [1:0] b);
        presetn <= 1'b0;
        lock_f <= l;
        bod_f <= b;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask

    task go_sleep;
        sleep_instr <= 1'b1;
        @(posedge pclk);
        sleep_instr <= 1'b0;
        @(posedge pclk);
    endtask

    task t_lock;
        rdc("lposc", SLPCLK_LPOSC_ADDR, 32'h0);
        rdc("xosc", AX, 32'h0);
        rdc("sleep", AS, 32'h0);
        v6 = trim_a;
        v4 = temp;
        chk("temp_rst", {2'h2, fsel}, temp);
        wr(SLPCLK_TRIM_A_ADDR, {26'h0, ~v6});
        wr(SLPCLK_TRIM_B_ADDR, {28'h0, ~v4});
        chk("trim_a", v6, trim_a);
        chk("temp", v4, temp);
        apb(1'b0, SLPCLK_TRIM_B_ADDR, 32'h0, 1'b0);
        chk("lock", 1'b1, rd[SLPCLK_LOCK_BIT]);
    endtask

    task t_trim;
        wr(SLPCLK_TRIM_A_ADDR, 32'h2A);
        wr(SLPCLK_TRIM_B_ADDR, 32'h05);
        chk("trim_a", 6'h2A, trim_a);
        chk("temp", 4'h5, temp);
        rdc("trim_b", SLPCLK_TRIM_B_ADDR, 32'h05);
    endtask

    task t_lp;
        lp_req <= 1'b1;
        repeat (8) @(posedge pclk);
        chk("lp_early", 1'b0, lp_gate);
        waitfor(0, 30);
        chk("lp_gate", 1'b1, lp_gate);
        lp_req <= 1'b0;
        wr(SLPCLK_LPOSC_ADDR, 32'h02);
        chk("lp_on", 1'b1, lp_on);
        chk("lp_idle", 1'b0, lp_gate);
    endtask

    // crystal start-up with the shortest count, then quick re-request
    task t_xtal;
        wr(AX, 32'h03);
        rdc("unprot", AX, 32'h0);
        unlock(32'h03);
        chk("ovr", 1'b1, x_ovr);
        chk("out_en", 1'b1, x_oe);
        x_req <= 1'b1;
        repeat (2790) @(posedge pclk);
        chk("su_early", 1'b0, x_gate);
        waitfor(1, 500);
        chk("su_done", 1'b1, x_gate);
        unlock(32'h37);
        rdc("frozen", AX, 32'h03);
        x_req <= 1'b0;
        repeat (4) @(posedge pclk);
        chk("x_drop", 1'b0, x_gate);
        chk("x_run", 1'b1, x_on);
        x_req <= 1'b1;
        waitfor(1, 14);
        chk("x_quick", 1'b1, x_gate);
    endtask

    task t_resel;
        unlock(32'h0);
        x_req <= 1'b0;
        n = 0;
        do begin
            apb(1'b0, 8'h30, 32'h0, 1'b0);
            n++;
        end while (rd[6] !== 1'b0 && n < 40);
        chk("stable", 1'b0, rd[6]);
        unlock(32'h05);
        rdc("resel", AX, 32'h05);
        chk("ext_oe", 1'b0, x_oe);
        x_req <= 1'b1;
        waitfor(1, 20);
        chk("ext_fast", 1'b1, x_gate);
        x_req <= 1'b0;
    endtask

    // stall: 1 holds main clock not ready, 2 holds brown-out not ready
    task t_sleep(input logic [1:0] m, input logic [5:0] pa, input logic [1:0] stall);
        wr(AS, {29'h0, m, 1'b1});
        go_sleep();
        chk("cpu_en", 1'b0, cpu_en);
        chk("halted_slp", 1'b1, halted);
        chk("periph", pa, pact);
        // main clock stays only in idle, or in standby with its own bit set
        chk("main_osc", m == SLPCLK_SM_IDLE || (m == SLPCLK_SM_STBY && pa[5]),
            mosc);
        rdc("mode", SLPCLK_STATUS_ADDR, {27'h0, 5'h02 << m});
        mclk_rdy <= (stall != 2'd1);
        bod_rdy <= (stall != 2'd2);
        wake_irq <= 1'b1;
        waitfor(2, 20);
        if (stall == 2'd0) begin
            chk("wake", int'(SLPCLK_WAKE_CYC) + 2, n);
        end else begin
            chk("stretch", 1'b0, cpu_en);
            mclk_rdy <= 1'b1;
            bod_rdy <= 1'b1;
            waitfor(2, 4);
            chk("woke", 1'b1, cpu_en);
        end
        wake_irq <= 1'b0;
        chk("halted", 1'b0, halted);
        rdc("kept", AS, {29'h0, m, 1'b1});
    endtask

    task t_noirq;
        irq_en <= 1'b0;
        wr(AS, 32'h01);
        go_sleep();
        wake_irq <= 1'b1;
        repeat (20) @(posedge pclk);
        chk("no_irq", 1'b0, cpu_en);
        dbg <= 1'b1;
        waitfor(2, 12);
        chk("dbg", 1'b1, cpu_en);
        dbg <= 1'b0;
        wake_irq <= 1'b0;
        irq_en <= 1'b1;
        wr(AS, 32'h07);
        go_sleep();
        chk("reserved", 1'b1, cpu_en);
    endtask

    // main sequence: locked fuse first, then unlocked with brown-out wait
    initial begin
        pclk = 1'b0;
        lp_tick = 1'b0;
        {psel, penable, pwrite, sleep_instr, wake_irq, dbg, lp_req, x_req} = 8'h00;
        {irq_en, bod_rdy, mclk_rdy} = 3'h7;
        paddr = 8'h00;
        pwdata = 32'h0;
        fsel = 2'h1;
        prsb = 6'h2A;
        do_reset(1'b1, 2'h0);
        t_lock();
        do_reset(1'b0, 2'h3);
        t_trim();
        t_lp();
        t_xtal();
        t_resel();
        t_sleep(SLPCLK_SM_IDLE, 6'h3F, 2'd0);
        t_sleep(SLPCLK_SM_STBY, 6'h2A, 2'd0);
        t_sleep(SLPCLK_SM_POWER_DOWN_MODE, 6'h00, 2'd1);
        // standby with the main clock source stopped stretches the wake
        prsb <= 6'h0A;
        t_sleep(SLPCLK_SM_STBY, 6'h0A, 2'd1);
        t_sleep(SLPCLK_SM_IDLE, 6'h3F, 2'd2);
        t_noirq();
        results();
    end
endmodule // sleep_and_low_power_clock_control_tb
